// ===== shared/imo_regs.svh
`ifndef IMO_REGS_SVH
`define IMO_REGS_SVH

// register byte addresses, upper byte of each word is address + 1
`define IMO_ADDR_ACCEL_Y_LOW    7'h14
`define IMO_ADDR_ACCEL_Y_HIGH   7'h16
`define IMO_ADDR_ACCEL_Z_LOW    7'h18
`define IMO_ADDR_ACCEL_Z_HIGH   7'h1a
`define IMO_ADDR_TEMPERATURE    7'h1c
`define IMO_ADDR_SYNC_ELAPSED   7'h1e
`define IMO_ADDR_UPDATE_COUNT   7'h22
`define IMO_ADDR_DANG_X_LOW     7'h24
`define IMO_ADDR_DANG_X_HIGH    7'h26
`define IMO_ADDR_DANG_Y_LOW     7'h28
`define IMO_ADDR_DANG_Y_HIGH    7'h2a
`define IMO_ADDR_DANG_Z_LOW     7'h2c
`define IMO_ADDR_DANG_Z_HIGH    7'h2e

// reset and read values
`define IMO_COUNT_RESET         16'h0000
`define IMO_UNMAPPED_READ       16'h0000
`define IMO_WORD_ZERO           16'h0000

// miscellaneous control field: sync mode in bits 4..2
`define IMO_SYNC_MODE_SCALED    3'h2

// spi frame layout
`define IMO_FRAME_BITS          5'h10
`define IMO_FRAME_WRITE_BIT     15
`define IMO_FRAME_ADDR_MSB      14
`define IMO_FRAME_ADDR_LSB      8

// timing
`define IMO_CLK_MHZ             10
`define IMO_SAMPLE_RATE_SPS     2000
`define IMO_SAMPLE_DIV          ((`IMO_CLK_MHZ * 1000000) / `IMO_SAMPLE_RATE_SPS)
`define IMO_TS_LSB_NS           49020
`define IMO_TS_LSB_CYC          ((`IMO_TS_LSB_NS * `IMO_CLK_MHZ) / 1000)

// delta angle full scale per variant, degrees
`define IMO_DANG_RANGE_V1       360
`define IMO_DANG_RANGE_V2       720
`define IMO_DANG_RANGE_V3       2160
// right shift folding gyro lsb, 1/(2*fs) and 2^31/range together
`define IMO_DANG_SHIFT_V1       6'h02
`define IMO_DANG_SHIFT_V2       6'h03
`define IMO_DANG_SHIFT_V3       6'h04

`endif

// ===== shared/imo_pkg.sv
package imo_pkg;

	// one set of sensor results, same clock domain
	typedef struct packed {
		logic [31:0] gyro_x;
		logic [31:0] gyro_y;
		logic [31:0] gyro_z;
		logic [31:0] accel_y;
		logic [31:0] accel_z;
		logic [15:0] temperature;
	} imo_sample_t;

	// output register image, loaded as one unit
	typedef struct packed {
		logic [31:0] accel_y;
		logic [31:0] accel_z;
		logic [15:0] temperature;
		logic [15:0] sync_elapsed;
		logic [15:0] update_count;
		logic [31:0] dang_x;
		logic [31:0] dang_y;
		logic [31:0] dang_z;
	} imo_snapshot_t;

	typedef enum logic [1:0] {
		IMO_VARIANT_1 = 2'h0,
		IMO_VARIANT_2 = 2'h1,
		IMO_VARIANT_3 = 2'h2
	} imo_variant_t;

	typedef enum logic {
		IMO_SPI_IDLE   = 1'b0,
		IMO_SPI_ACTIVE = 1'b1
	} imo_spi_state_t;

endpackage

// ===== hw/imo_delta_integ.sv
`timescale 1ns/100ps
`default_nettype none

module imo_delta_integ (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        soft_reset,
	// pacing
	input  wire logic        sample_tick,
	input  wire logic        update,
	// data
	input  wire logic [31:0] rate,
	input  wire logic [5:0]  shift,
	output logic [31:0]      delta
);

	logic signed [31:0] prev_rate;
	logic signed [48:0] acc;
	logic signed [48:0] next_acc;
	logic signed [48:0] scaled;

	// current plus previous rate, summed over the decimation window
	always_comb begin
		next_acc = acc + 49'(signed'(rate)) + 49'(prev_rate);
		scaled   = next_acc >>> shift;
	end

	// previous sample memory, one per sample tick
	always_ff @(posedge clock) begin
		if (!nrst || soft_reset) begin
			prev_rate <= '0;
		end else if (sample_tick) begin
			prev_rate <= signed'(rate);
		end
	end

	// window restarts on the update that closes it
	always_ff @(posedge clock) begin
		if (!nrst || soft_reset) begin
			acc   <= '0;
			delta <= '0;
		end else if (sample_tick && update) begin
			acc   <= '0;
			delta <= scaled[31:0]; // [RULE13] [RULE17]
		end else if (sample_tick) begin
			acc   <= next_acc; // [RULE13]
		end
	end

endmodule

`default_nettype wire

// ===== hw/imo_sync_stamp.sv
`timescale 1ns/100ps
`default_nettype none
`include "imo_regs.svh"

module imo_sync_stamp (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        nrst,
	// sync pin, asynchronous
	input  wire logic        sync_pin,
	// control
	input  wire logic        scaled_mode,
	input  wire logic        capture,
	output logic [15:0]      stamp
);

	localparam logic [9:0] LSB_LAST = 10'(`IMO_TS_LSB_CYC - 1);

	logic [2:0]  sync_sr;
	logic        sync_f;
	logic        sync_f_d;
	logic        sync_edge;
	logic [9:0]  lsb_cnt;
	logic [15:0] elapsed;

	assign sync_edge = sync_f && !sync_f_d;

	// three stage synchroniser, level taken when stages two and three agree
	always_ff @(posedge clock) begin
		if (!nrst) begin
			sync_sr  <= 3'h0;
			sync_f   <= 1'b0;
			sync_f_d <= 1'b0;
		end else begin
			sync_sr  <= {sync_sr[1:0], sync_pin};
			sync_f   <= (sync_sr[1] == sync_sr[2]) ? sync_sr[2] : sync_f;
			sync_f_d <= sync_f;
		end
	end

	// elapsed time since the last rising sync edge, free wrap
	always_ff @(posedge clock) begin
		if (!nrst || sync_edge) begin
			lsb_cnt <= '0;
			elapsed <= `IMO_WORD_ZERO; // [RULE6]
		end else if (lsb_cnt == LSB_LAST) begin
			lsb_cnt <= '0;
			elapsed <= elapsed + 16'h0001; // [RULE6]
		end else begin
			lsb_cnt <= lsb_cnt + 10'h001;
		end
	end

	// stamp of the final sample; old value wins over a same-cycle edge
	always_ff @(posedge clock) begin
		if (!nrst) begin
			stamp <= `IMO_WORD_ZERO;
		end else if (capture) begin
			stamp <= scaled_mode ? elapsed : `IMO_WORD_ZERO; // [RULE7] [RULE8]
		end
	end

endmodule

`default_nettype wire

// ===== hw/imo_output_regs.sv
// Behaviour
// RULE1: accel y low word readable at 0x14
// RULE2: accel y high word at 0x16, twos complement
// RULE3: accel z low word readable at 0x18
// RULE4: accel z high word at 0x1a, twos complement
// RULE5: temperature word at 0x1c, 0.1 C steps
// RULE6: elapsed time since sync at 0x1e
// RULE7: time stamp valid in scaled sync mode
// RULE8: stamp taken at last sample of update
// RULE9: update counter clears on reset events
// RULE10: counter increments on each output update
// RULE11: counter wraps from 0xffff to zero
// RULE12: counter readable at 0x22
// RULE13: delta angle by trapezoidal integration
// RULE14: window length is decimation plus one
// RULE15: internal sampling nominal 2000 samples per second
// RULE16: host may rescale by measured ready rate
// RULE17: delta angle as 32-bit pair per axis
// RULE18: delta range depends on product variant
// RULE19: accel words pair, low is lower half
// RULE20: delta upper word lsb range over 2^15
// RULE21: all outputs load from one update
// RULE22: host writes leave outputs unchanged
`timescale 1ns/100ps
`default_nettype none
`include "imo_regs.svh"

module imo_output_regs
	import imo_pkg::*;
#(
	parameter int SAMPLE_DIV = `IMO_SAMPLE_DIV
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        soft_reset,
	// sensor side, same clock domain
	input  wire imo_sample_t sample,
	input  wire logic [1:0]  variant_select,
	// control fields held elsewhere
	input  wire logic [15:0] decimation_setting,
	input  wire logic [2:0]  sync_mode,
	// external sync pin
	input  wire logic        sync_pin,
	// spi pins
	input  wire logic        spi_cs_n,
	input  wire logic        spi_sclk,
	input  wire logic        spi_mosi,
	output logic             spi_miso,
	output logic             spi_miso_oe,
	// data ready pulse
	output logic             data_ready_output
);

	localparam logic [12:0] DIV_LAST = 13'(SAMPLE_DIV - 1);

	////////////////////////////////////////////////////////////////////////
	// read decode

	function automatic logic [15:0] imo_read_word(input logic [6:0] addr,
		input imo_snapshot_t s);
		logic [15:0] w;
		w = `IMO_UNMAPPED_READ;
		unique case ({addr[6:1], 1'b0})
			`IMO_ADDR_ACCEL_Y_LOW:  w = s.accel_y[15:0];   // [RULE1] [RULE19]
			`IMO_ADDR_ACCEL_Y_HIGH: w = s.accel_y[31:16];  // [RULE2] [RULE19]
			`IMO_ADDR_ACCEL_Z_LOW:  w = s.accel_z[15:0];   // [RULE3] [RULE19]
			`IMO_ADDR_ACCEL_Z_HIGH: w = s.accel_z[31:16];  // [RULE4] [RULE19]
			`IMO_ADDR_TEMPERATURE:  w = s.temperature;     // [RULE5]
			`IMO_ADDR_SYNC_ELAPSED: w = s.sync_elapsed;    // [RULE6]
			`IMO_ADDR_UPDATE_COUNT: w = s.update_count;    // [RULE12]
			`IMO_ADDR_DANG_X_LOW:   w = s.dang_x[15:0];    // [RULE17]
			`IMO_ADDR_DANG_X_HIGH:  w = s.dang_x[31:16];   // [RULE17] [RULE20]
			`IMO_ADDR_DANG_Y_LOW:   w = s.dang_y[15:0];    // [RULE17]
			`IMO_ADDR_DANG_Y_HIGH:  w = s.dang_y[31:16];   // [RULE17] [RULE20]
			`IMO_ADDR_DANG_Z_LOW:   w = s.dang_z[15:0];    // [RULE17]
			`IMO_ADDR_DANG_Z_HIGH:  w = s.dang_z[31:16];   // [RULE17] [RULE20]
			default:                w = `IMO_UNMAPPED_READ;
		endcase
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// variant strap, caught once after reset release

	imo_variant_t variant_q;
	logic         strap_done;
	logic [5:0]   dang_shift;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			variant_q  <= IMO_VARIANT_1;
			strap_done <= 1'b0;
		end else if (!strap_done) begin
			variant_q  <= imo_variant_t'(variant_select);
			strap_done <= 1'b1;
		end
	end

	// full scale 360, 720 or 2160 degrees maps to a scaling shift
	always_comb begin
		unique case (variant_q)
			IMO_VARIANT_1: dang_shift = `IMO_DANG_SHIFT_V1; // [RULE18]
			IMO_VARIANT_2: dang_shift = `IMO_DANG_SHIFT_V2; // [RULE18]
			IMO_VARIANT_3: dang_shift = `IMO_DANG_SHIFT_V3; // [RULE18]
			default:       dang_shift = `IMO_DANG_SHIFT_V1;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// internal sample clock and decimation

	logic [12:0] div_cnt;
	logic        sample_tick;
	logic [15:0] dec_cnt;
	logic        update;

	assign update = sample_tick && (dec_cnt == decimation_setting); // [RULE14]

	// divider gives one tick per nominal sample period
	always_ff @(posedge clock) begin
		if (!nrst) begin
			div_cnt     <= '0;
			sample_tick <= 1'b0;
		end else begin
			sample_tick <= (div_cnt == DIV_LAST); // [RULE15]
			div_cnt     <= (div_cnt == DIV_LAST) ? 13'h0000 : div_cnt + 13'h0001;
		end
	end

	// decimation counter spans setting plus one samples
	always_ff @(posedge clock) begin
		if (!nrst || soft_reset) begin
			dec_cnt <= 16'h0000;
		end else if (update) begin
			dec_cnt <= 16'h0000; // [RULE14]
		end else if (sample_tick) begin
			dec_cnt <= dec_cnt + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// delta angle integrators and time stamp

	logic [31:0] dang [3];
	logic [31:0] gyro [3];
	logic [15:0] stamp;

	assign gyro[0] = sample.gyro_x;
	assign gyro[1] = sample.gyro_y;
	assign gyro[2] = sample.gyro_z;

	// one identical integrator per axis
	for (genvar i = 0; i < 3; i++) begin : g_axis
		imo_delta_integ u_integ (
			.clock       (clock),
			.nrst        (nrst),
			.soft_reset  (soft_reset),
			.sample_tick (sample_tick),
			.update      (update),
			.rate        (gyro[i]),
			.shift       (dang_shift),
			.delta       (dang[i])
		);
	end

	imo_sync_stamp u_stamp (
		.clock       (clock),
		.nrst        (nrst),
		.sync_pin    (sync_pin),
		.scaled_mode (sync_mode == `IMO_SYNC_MODE_SCALED), // [RULE7]
		.capture     (update),
		.stamp       (stamp)
	);

	////////////////////////////////////////////////////////////////////////
	// output register image

	imo_snapshot_t snap;
	logic          load_d;

	// integrators and stamp settle one cycle after the update tick,
	// so the whole image is taken then; no partial image is ever visible
	always_ff @(posedge clock) begin
		if (!nrst || soft_reset) begin
			load_d <= 1'b0;
		end else begin
			load_d <= update;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			snap <= '0;
		end else if (soft_reset) begin
			snap.update_count <= `IMO_COUNT_RESET; // [RULE9]
		end else if (load_d) begin
			snap.accel_y      <= sample.accel_y;      // [RULE21]
			snap.accel_z      <= sample.accel_z;      // [RULE21]
			snap.temperature  <= sample.temperature;  // [RULE5]
			snap.sync_elapsed <= stamp;               // [RULE8]
			snap.dang_x       <= dang[0];             // [RULE21]
			snap.dang_y       <= dang[1];
			snap.dang_z       <= dang[2];
			snap.update_count <= snap.update_count + 16'h0001; // [RULE10] [RULE11]
		end
	end

	// ready pulse rises on the same edge that loads the image
	always_ff @(posedge clock) begin
		if (!nrst) begin
			data_ready_output <= 1'b0;
		end else begin
			data_ready_output <= load_d && !soft_reset;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// spi pin synchronisers

	logic [2:0] pin_raw;
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic [2:0] pin_s3;
	logic [2:0] pin_f;
	logic [2:0] pin_f_d;

	assign pin_raw = {spi_cs_n, spi_sclk, spi_mosi};

	// three stages each; limits sclk to well under a tenth of clock
	for (genvar p = 0; p < 3; p++) begin : g_pin
		always_ff @(posedge clock) begin
			if (!nrst) begin
				pin_s1[p]  <= 1'b1;
				pin_s2[p]  <= 1'b1;
				pin_s3[p]  <= 1'b1;
				pin_f[p]   <= 1'b1;
				pin_f_d[p] <= 1'b1;
			end else begin
				pin_s1[p]  <= pin_raw[p];
				pin_s2[p]  <= pin_s1[p];
				pin_s3[p]  <= pin_s2[p];
				pin_f[p]   <= (pin_s2[p] == pin_s3[p]) ? pin_s3[p] : pin_f[p];
				pin_f_d[p] <= pin_f[p];
			end
		end
	end

	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;

	assign cs_fall   = pin_f_d[2] && !pin_f[2];
	assign cs_rise   = !pin_f_d[2] && pin_f[2];
	assign sclk_rise = !pin_f_d[1] && pin_f[1];
	assign sclk_fall = pin_f_d[1] && !pin_f[1];

	////////////////////////////////////////////////////////////////////////
	// spi frame engine, mode 3, reply comes in the next frame

	imo_spi_state_t spi_state;
	logic [15:0]    rx_shift;
	logic [15:0]    tx_shift;
	logic [4:0]     bit_cnt;
	logic [6:0]     pend_addr;
	logic [15:0]    reply_word;

	// decoded word for the pending address, sliced below without a call select
	assign reply_word = imo_read_word(pend_addr, snap);

	always_ff @(posedge clock) begin
		if (!nrst) begin
			spi_state   <= IMO_SPI_IDLE;
			rx_shift    <= 16'h0000;
			tx_shift    <= 16'h0000;
			bit_cnt     <= 5'h00;
			pend_addr   <= 7'h00;
			spi_miso    <= 1'b0;
			spi_miso_oe <= 1'b0;
		end else begin
			unique case (spi_state)
				IMO_SPI_IDLE: begin
					spi_miso_oe <= 1'b0;
					if (cs_fall) begin
						// reply latched whole, so an update mid frame cannot tear it
						tx_shift    <= reply_word;
						spi_miso    <= reply_word[15];
						spi_miso_oe <= 1'b1;
						bit_cnt     <= 5'h00;
						spi_state   <= IMO_SPI_ACTIVE;
					end
				end
				IMO_SPI_ACTIVE: begin
					if (cs_rise) begin
						spi_state   <= IMO_SPI_IDLE;
						spi_miso_oe <= 1'b0;
						// writes and short frames are dropped
						if (bit_cnt == `IMO_FRAME_BITS && !rx_shift[`IMO_FRAME_WRITE_BIT]) begin
							pend_addr <= rx_shift[`IMO_FRAME_ADDR_MSB:`IMO_FRAME_ADDR_LSB];
						end // [RULE22]
					end else if (sclk_rise) begin
						rx_shift <= {rx_shift[14:0], pin_f[0]};
						if (bit_cnt != `IMO_FRAME_BITS) begin
							bit_cnt <= bit_cnt + 5'h01;
						end
					end else if (sclk_fall) begin
						tx_shift <= {tx_shift[14:0], 1'b0};
						spi_miso <= tx_shift[14];
					end
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// ===== testbench/imo_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////
module imo_regs_sva #(
	parameter int SAMPLE_DIV = 5000
) (
	// clock and reset
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        soft_reset,
	// control
	input wire logic [15:0] decimation_setting,
	// spi pins
	input wire logic        spi_cs_n,
	input wire logic        spi_sclk,
	input wire logic        spi_miso,
	input wire logic        spi_miso_oe,
	// pacing
	input wire logic        data_ready_output
);
	int   gap;
	logic seen;

	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	// cycles since last ready; soft reset restarts the window, so skip one gap
	always_ff @(posedge clock) begin
		if (!nrst || soft_reset) begin
			gap  <= 0;
			seen <= 1'b0;
		end else if (data_ready_output) begin
			gap  <= 1;
			seen <= 1'b1;
		end else begin
			gap <= gap + 1;
		end
	end

	////////////////////////////////////////
	ready_pulse_a: assert property (data_ready_output |=> !data_ready_output)
		else $error("ready pulse longer than one cycle");
	update_gap_a: assert property (data_ready_output && seen |->
		gap == (int'(decimation_setting) + 1) * SAMPLE_DIV)
		else $error("update spacing differs from window length");
	reset_quiet_a: assert property ($rose(nrst) |-> (!spi_miso_oe && !data_ready_output)[*2])
		else $error("outputs active right after reset");
	oe_rise_a: assert property ($fell(spi_cs_n) |-> ##[2:8] spi_miso_oe)
		else $error("miso not driven after select");
	oe_hold_a: assert property ((!spi_cs_n)[*8] |-> spi_miso_oe)
		else $error("miso released inside frame");
	oe_fall_a: assert property ($rose(spi_cs_n) |-> ##[2:8] !spi_miso_oe)
		else $error("miso kept after deselect");
	oe_idle_a: assert property (spi_cs_n[*8] |-> !spi_miso_oe)
		else $error("miso driven while idle");
	miso_steady_a: assert property ((spi_sclk && spi_miso_oe)[*8] |-> $stable(spi_miso))
		else $error("miso moved while clock high");
endmodule

`default_nettype wire

// ===== testbench/imo_host.sv
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////
module imo_host (
	// clock
	input wire logic clock,
	// spi pins
	input wire logic spi_miso,
	output logic     spi_cs_n,
	output logic     spi_sclk,
	output logic     spi_mosi
);
	// mode 3 idle: select high, clock high
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b1;
		spi_mosi = 1'b1;
	end

	// half period of 10 clocks stays clear of the 3-flop pin filters
	task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
		rx = 16'h0000;
		@(negedge clock) spi_cs_n = 1'b0;
		repeat (10) @(negedge clock);
		for (int i = 15; i >= 0; i--) begin
			// reply bit stands from select or the previous fall, so take it before the next fall
			rx[i] = spi_miso;
			spi_sclk = 1'b0;
			spi_mosi = tx[i];
			repeat (10) @(negedge clock);
			spi_sclk = 1'b1;
			repeat (10) @(negedge clock);
		end
		spi_cs_n = 1'b1;
		repeat (12) @(negedge clock);
	endtask
endmodule

`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "imo_regs.svh"

bind imo_output_regs imo_regs_sva #(.SAMPLE_DIV(SAMPLE_DIV)) imo_regs_sva_inst (
	.clock(clock), .nrst(nrst), .soft_reset(soft_reset), .decimation_setting(decimation_setting),
	.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
	.data_ready_output(data_ready_output));

////////////////////////////////////////
module tb
	import imo_pkg::*;
;
	localparam int DIV = 20;
	localparam int DEC = 127;

	logic        clock = 1'b0;
	logic        nrst, soft_reset, sync_pin;
	logic        spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, data_ready_output;
	imo_sample_t sample;
	logic [1:0]  variant_select;
	logic [15:0] decimation_setting, rx;
	logic [2:0]  sync_mode;
	int          failures = 0, checks = 0, ready_cnt = 0, cycles = 0, dx;
	int          shift [3] = '{`IMO_DANG_SHIFT_V1, `IMO_DANG_SHIFT_V2, `IMO_DANG_SHIFT_V3};

	imo_output_regs #(.SAMPLE_DIV(DIV)) imo_output_regs_inst (
		.clock(clock), .nrst(nrst), .soft_reset(soft_reset), .sample(sample),
		.variant_select(variant_select), .decimation_setting(decimation_setting),
		.sync_mode(sync_mode), .sync_pin(sync_pin), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
		.data_ready_output(data_ready_output));

	imo_host imo_host_inst (.clock(clock), .spi_miso(spi_miso), .spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk), .spi_mosi(spi_mosi));

	always #50 clock = ~clock;

	// count updates at the edge, where the registered pulse is settled; cut a hang short
	always @(posedge clock) begin
		cycles++;
		if (data_ready_output === 1'b1) begin
			ready_cnt++;
		end
		if (cycles == 90000) begin
			failures++;
			report_and_stop();
		end
	end

	////////////////////////////////////////
	task automatic report_and_stop();
		if (failures == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// the reply rides in the frame after the address, so send it twice
	task automatic chk(input logic [6:0] addr, input logic [15:0] exp);
		logic [15:0] got;
		imo_host_inst.frame({1'b0, addr, 8'h00}, got);
		imo_host_inst.frame({1'b0, addr, 8'h00}, got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] reg %h expected %h seen %h", addr, exp, got);
		end
	endtask

	// cycle counts timed by the host side
	task automatic chk_cyc(input int exp, input int got);
		checks++;
		if (got != exp) begin
			failures++;
			$display("[ERR] ready period expected %0d seen %0d", exp, got);
		end
	endtask

	// one extra edge lets the update counter above catch the pulse
	task automatic wait_ready();
		do @(negedge clock); while (data_ready_output !== 1'b1);
		@(negedge clock);
	endtask

	task automatic do_reset(input logic [1:0] v);
		nrst = 1'b0;
		variant_select = v;
		repeat (10) @(negedge clock);
		nrst = 1'b1;
		ready_cnt = 0;
		repeat (5) @(negedge clock);
	endtask

	////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		soft_reset = 1'b0;
		sync_pin = 1'b0;
		sync_mode = 3'h0;
		decimation_setting = 16'h007f;
		variant_select = 2'h0;
		sample = '0;
		sample.gyro_x = 32'h0000_0100;
		sample.gyro_y = 32'h0000_0200;
		sample.gyro_z = 32'hffff_ff00;
		sample.accel_y = 32'h1234_5678;
		sample.accel_z = 32'h8300_0001;
		sample.temperature = 16'hfe70;
		// first window lacks one previous rate, later windows are full
		for (int v = 0; v < 3; v++) begin
			do_reset(v[1:0]);
			wait_ready();
			dx = ((2 * DEC + 1) * 256) >>> shift[v];
			chk(`IMO_ADDR_DANG_X_LOW, dx[15:0]);
			wait_ready();
			wait_ready();
			dx = (2 * (DEC + 1) * 256) >>> shift[v];
			chk(`IMO_ADDR_DANG_X_LOW, dx[15:0]);
			chk(`IMO_ADDR_DANG_X_HIGH, dx[31:16]);
			dx = -dx;
			chk(`IMO_ADDR_DANG_Z_LOW, dx[15:0]);
			chk(`IMO_ADDR_DANG_Z_HIGH, dx[31:16]);
		end
		// inputs held constant, so these words survive any update
		chk(`IMO_ADDR_ACCEL_Y_LOW, 16'h5678);
		chk(`IMO_ADDR_ACCEL_Y_HIGH, 16'h1234);
		chk(`IMO_ADDR_ACCEL_Z_LOW, 16'h0001);
		chk(`IMO_ADDR_ACCEL_Z_HIGH, 16'h8300);
		chk(`IMO_ADDR_TEMPERATURE, 16'hfe70);
		imo_host_inst.frame({1'b1, `IMO_ADDR_ACCEL_Y_LOW, 8'ha5}, rx);
		chk(`IMO_ADDR_ACCEL_Y_LOW, 16'h5678);
		chk(7'h20, `IMO_UNMAPPED_READ);
		// counter against the pulses seen, then across a soft reset
		wait_ready();
		chk(`IMO_ADDR_UPDATE_COUNT, ready_cnt[15:0]);
		soft_reset = 1'b1;
		@(negedge clock);
		soft_reset = 1'b0;
		ready_cnt = 0;
		chk(`IMO_ADDR_UPDATE_COUNT, `IMO_COUNT_RESET);
		wait_ready();
		chk(`IMO_ADDR_UPDATE_COUNT, 16'h0001);
		// stamp is zero outside scaled mode, then counts from the sync edge
		wait_ready();
		chk(`IMO_ADDR_SYNC_ELAPSED, `IMO_WORD_ZERO);
		sync_mode = `IMO_SYNC_MODE_SCALED;
		wait_ready();
		sync_pin = 1'b1;
		repeat (5) @(negedge clock);
		sync_pin = 1'b0;
		wait_ready();
		dx = ((DEC + 1) * DIV - 8) / `IMO_TS_LSB_CYC;
		chk(`IMO_ADDR_SYNC_ELAPSED, dx[15:0]);
		// one-sample window: host times the ready rate to rescale deltas
		decimation_setting = 16'h0000;
		soft_reset = 1'b1;
		@(negedge clock);
		soft_reset = 1'b0;
		wait_ready();
		dx = 1;
		do begin
			@(negedge clock);
			dx++;
		end while (data_ready_output !== 1'b1);
		chk_cyc(DIV, dx);
		dx = (2 * 256) >>> shift[2];
		chk(`IMO_ADDR_DANG_X_LOW, dx[15:0]);
		dx = (2 * 512) >>> shift[2];
		chk(`IMO_ADDR_DANG_Y_LOW, dx[15:0]);
		chk(`IMO_ADDR_DANG_Y_HIGH, 16'h0000);
		report_and_stop();
	end
endmodule

`default_nettype wire
